// >>> shared/touch_seq_pkg.sv
// Constants and types shared by the touch conversion sequencer and its converter
// What this block does
// - Wait at least 1 ms after interrupt
// - Touch while powered down still flags touch, not interrupt
// - No sequencing while powered down
// - 12-bit X, Y results paced by settings
// - Full plate voltage maps to code 4095
// - Converter monotonic with no missing codes
// - Retouch between conversions raises another interrupt
// - Works from 12 to 40 MHz clock
// - Read clears interrupt unless one is rising
// - Reset clears results, control; rate is 32
// - Idle drives Y high, X low; sense X
package touch_seq_pkg;
  localparam int RESULT_W         = 12;
  localparam logic [11:0] FULL_SCALE = 12'hfff;
  localparam int SAR_STEP_CYCLES  = 4;
  // Plate pin indices into the 4-bit plate vectors
  localparam int PIN_X_HIGH = 0;
  localparam int PIN_X_LOW  = 1;
  localparam int PIN_Y_HIGH = 2;
  localparam int PIN_Y_LOW  = 3;
  // Control bits (low bits of control register 6)
  localparam int CTRL_W           = 8;
  localparam int CTRL_CONV_EN     = 0;
  localparam int CTRL_IRQ_TOUCH   = 1;
  localparam int CTRL_IRQ_DONE    = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h20;
  localparam logic [7:0] RATE_MIN   = 8'h09;
  // Timing
  localparam int CLK_KHZ          = 40000;
  localparam int SETTLE_TIME_US   = 1000;
  localparam int SETTLE_CYCLES    = (SETTLE_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int PACE_BASE_CYCLES = 35716;
  localparam int PACE_STEP_CYCLES = 4096;
  localparam int DETECT_CYCLES    = 16;
  localparam int CNT_W            = 21;
  typedef enum logic [2:0] {
    ST_OFF, ST_IDLE, ST_SETTLE, ST_CONV_X, ST_CONV_Y, ST_PACE, ST_DETECT
  } seq_state_t;
endpackage

// >>> rtl/sar_converter.sv
// Successive-approximation converter that steps a trial code against a comparator
module sar_converter
  import touch_seq_pkg::*;
#(
  parameter int STEP_CYCLES = SAR_STEP_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                start,
  input  wire logic                comp_above,
  output logic [RESULT_W-1:0]      trial_code,
  output logic                     busy,
  output logic                     done,
  output logic [RESULT_W-1:0]      result
);
  // Step counter is eight bits wide
  if (STEP_CYCLES < 1 || STEP_CYCLES > 256) begin : g_bad_step
    $error("STEP_CYCLES must be 1 to 256");
  end

  logic [RESULT_W-1:0] bit_q;
  logic [7:0]          step_cnt_q;

  // Binary search from MSB: every code is reachable and order is kept
  // binary search
  always_ff @(posedge clk) begin
    if (reset) begin
      trial_code <= '0;
      bit_q      <= '0;
      step_cnt_q <= '0;
      busy       <= 1'b0;
      done       <= 1'b0;
      result     <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy       <= 1'b1;
        bit_q      <= {1'b1, {(RESULT_W-1){1'b0}}};
        trial_code <= {1'b1, {(RESULT_W-1){1'b0}}};
        step_cnt_q <= '0;
      end else if (busy) begin
        if (step_cnt_q != 8'(STEP_CYCLES - 1)) begin
          step_cnt_q <= step_cnt_q + 8'h01;
        end else begin
          step_cnt_q <= '0;
          if (!comp_above) trial_code <= trial_code & ~bit_q;
          if (bit_q[0]) begin
            busy   <= 1'b0;
            done   <= 1'b1;
            result <= comp_above ? trial_code : (trial_code & ~bit_q);
          end else begin
            bit_q      <= bit_q >> 1;
            trial_code <= (comp_above ? trial_code : (trial_code & ~bit_q)) | (bit_q >> 1);
          end
        end
      end
    end
  end

  a_sar_span: assert property (@(posedge clk) disable iff (reset)
    start && !busy |-> ##(RESULT_W * STEP_CYCLES + 1) done)
    else $error("converter did not finish in twelve steps");
endmodule

// >>> rtl/touch_conversion_sequencer.sv
// Touch detect, settle, pacing and interrupt sequencing for a 4-wire resistive screen
module touch_conversion_sequencer
  import touch_seq_pkg::*;
#(
  parameter int SETTLE_WAIT = SETTLE_CYCLES,
  parameter int PACE_BASE   = PACE_BASE_CYCLES,
  parameter int PACE_STEP   = PACE_STEP_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                cfg_write,
  input  wire logic                cfg_sel_rate,
  input  wire logic [7:0]          cfg_data,
  input  wire logic                reg_read,
  input  wire logic [3:0]          plate_in,
  input  wire logic                comp_above,
  output logic [3:0]               plate_out,
  output logic [3:0]               plate_oe_n,
  output logic [RESULT_W-1:0]      dac_code,
  output logic [RESULT_W-1:0]      x_result,
  output logic [RESULT_W-1:0]      y_result,
  output logic                     touch_n,
  output logic                     irq
);
  if (SETTLE_WAIT < 1 || PACE_BASE < 1 || PACE_STEP < 0) begin : g_bad_timing
    $error("timing parameters out of range");
  end
  if (PACE_BASE + 255 * PACE_STEP >= (1 << CNT_W)) begin : g_bad_pace
    $error("pace exceeds counter");
  end

  seq_state_t          state_q;
  logic [7:0]          ctrl_q;
  logic [7:0]          rate_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [CNT_W-1:0]    wait_limit;
  logic                touched;
  logic                conv_start;
  logic                conv_busy;
  logic                conv_done;
  logic [RESULT_W-1:0] conv_result;
  logic [RESULT_W-1:0] trial_code;
  logic                ev_touch;
  logic                ev_done;
  logic                irq_event;
  logic [7:0]          plate_cfg;

  // Plate drive for a state: {oe_n, level}, pins in PIN_* order
  function automatic logic [7:0] plate_mode(input seq_state_t s);
    logic [7:0] m;
    m = 8'hf0;
    unique case (s)
      ST_OFF:                         m = 8'hf0;
      ST_IDLE, ST_DETECT, ST_SETTLE,
      ST_PACE:                        m = {4'b1001, 4'b0100};
      ST_CONV_X:                      m = {4'b1100, 4'b0001};
      ST_CONV_Y:                      m = {4'b0011, 4'b0100};
    endcase
    return m;
  endfunction

  assign touched = plate_in[PIN_X_HIGH];

  // pacing in clocks
  // Counted in clocks, so the point rate scales with the applied frequency
  // settle floor
  assign wait_limit = (CNT_W'(PACE_BASE) + CNT_W'(PACE_STEP) * CNT_W'(rate_q)
                       > CNT_W'(SETTLE_WAIT))
                    ? CNT_W'(PACE_BASE) + CNT_W'(PACE_STEP) * CNT_W'(rate_q)
                    : CNT_W'(SETTLE_WAIT);

  // Configuration copies of control and rate registers
  // reset values
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      rate_q <= RATE_RESET;
    end else if (cfg_write) begin
      if (cfg_sel_rate) begin
        // Rates below nine are not permitted; clamp rather than misbehave
        rate_q <= (cfg_data < RATE_MIN) ? RATE_MIN : cfg_data;
      end else begin
        ctrl_q <= cfg_data;
      end
    end
  end

  // Main sequence
  // edge driven only
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_OFF;
      cnt_q   <= '0;
    end else if (ctrl_q == 8'h00) begin
      state_q <= ST_OFF;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          state_q <= ST_IDLE;
          cnt_q   <= '0;
        end
        ST_IDLE: begin
          cnt_q <= '0;
          if (touched && ctrl_q[CTRL_CONV_EN]) state_q <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (cnt_q == CNT_W'(SETTLE_WAIT - 1)) begin
            cnt_q   <= '0;
            state_q <= ST_CONV_X;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_CONV_X: if (conv_done) state_q <= ST_CONV_Y;
        ST_CONV_Y: if (conv_done) begin
          state_q <= ST_PACE;
          cnt_q   <= '0;
        end
        ST_PACE: begin
          if (cnt_q >= wait_limit - 1'b1) begin
            cnt_q   <= '0;
            state_q <= ST_DETECT;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_DETECT: begin
          if (cnt_q == CNT_W'(DETECT_CYCLES - 1)) begin
            cnt_q   <= '0;
            state_q <= (touched && ctrl_q[CTRL_CONV_EN]) ? ST_CONV_X : ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  assign conv_start = (state_q == ST_SETTLE && cnt_q == CNT_W'(SETTLE_WAIT - 1))
                   || (state_q == ST_DETECT && cnt_q == CNT_W'(DETECT_CYCLES - 1)
                       && touched && ctrl_q[CTRL_CONV_EN])
                   || (state_q == ST_CONV_X && conv_done);

  sar_converter #(
    .STEP_CYCLES (SAR_STEP_CYCLES)
  ) u_sar (
    .clk        (clk),
    .reset      (reset),
    .start      (conv_start),
    .comp_above (comp_above),
    .trial_code (trial_code),
    .busy       (conv_busy),
    .done       (conv_done),
    .result     (conv_result)
  );

  // Results change only when a conversion finishes
  // hold results
  always_ff @(posedge clk) begin
    if (reset) begin
      x_result <= '0;
      y_result <= '0;
    end else if (conv_done) begin
      if (state_q == ST_CONV_X) x_result <= conv_result;
      if (state_q == ST_CONV_Y) y_result <= conv_result;
    end
  end

  // Touch-change events: new touch from idle, lift seen at detect
  assign ev_touch  = ctrl_q[CTRL_IRQ_TOUCH] &&
                     ((state_q == ST_IDLE && touched && ctrl_q[CTRL_CONV_EN])
                   || (state_q == ST_DETECT && cnt_q == CNT_W'(DETECT_CYCLES - 1) && !touched));
  assign ev_done   = ctrl_q[CTRL_IRQ_DONE] && conv_done && state_q == ST_CONV_Y;
  assign irq_event = ev_touch || ev_done;

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (irq_event) begin
      irq <= 1'b1;
    end else if (reg_read || (cfg_write && !cfg_sel_rate && cfg_data == 8'h00)) begin
      irq <= 1'b0;
    end
  end

  // Touch output follows the sense plate outside the X and Y conversions, even while powered down
  // touch flag
  always_ff @(posedge clk) begin
    if (reset) begin
      touch_n <= 1'b1;
    end else if (state_q != ST_CONV_X && state_q != ST_CONV_Y) begin
      touch_n <= ~touched;
    end
  end

  assign plate_cfg = plate_mode(state_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      plate_out  <= 4'h0;
      plate_oe_n <= 4'hf;
      dac_code   <= '0;
    end else begin
      plate_out  <= plate_cfg[3:0];
      plate_oe_n <= plate_cfg[7:4];
      dac_code   <= trial_code;
    end
  end

  // Helper: cycles since the last interrupt event
  logic [CNT_W-1:0] since_irq_q;
  always_ff @(posedge clk) begin
    if (reset || irq_event) since_irq_q <= '0;
    else if (since_irq_q != '1) since_irq_q <= since_irq_q + 1'b1;
  end

  a_settle_after_irq: assert property (@(posedge clk) disable iff (reset)
    conv_start && ctrl_q[CTRL_IRQ_TOUCH] && ctrl_q[CTRL_IRQ_DONE]
    |-> since_irq_q >= CNT_W'(SETTLE_WAIT) - 1'b1)
    else $error("conversion started inside settle window");
  a_read_clears: assert property (@(posedge clk) disable iff (reset)
    irq && reg_read && !irq_event && !cfg_write |=> !irq)
    else $error("read did not clear interrupt");
  a_event_wins: assert property (@(posedge clk) disable iff (reset)
    irq_event |=> irq)
    else $error("interrupt lost against clear");
  a_idle_drive: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_IDLE |=> plate_out[PIN_Y_HIGH] && !plate_oe_n[PIN_Y_HIGH]
                        && !plate_out[PIN_X_LOW] && !plate_oe_n[PIN_X_LOW])
    else $error("idle plate drive wrong");
  a_touch_flag: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_IDLE && touched |=> !touch_n)
    else $error("touch output missed touch");
  a_result_hold: assert property (@(posedge clk) disable iff (reset)
    !conv_done |=> $stable(x_result) && $stable(y_result))
    else $error("result changed without conversion");
  a_x_then_y: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_CONV_X && conv_done && ctrl_q != 8'h00 |=> state_q == ST_CONV_Y && conv_busy)
    else $error("Y conversion did not follow X");
  a_retouch_irq: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_IDLE && touched && ctrl_q[CTRL_CONV_EN] && ctrl_q[CTRL_IRQ_TOUCH]
    ##1 state_q == ST_SETTLE |-> irq)
    else $error("retouch gave no interrupt");
  a_off_quiet: assert property (@(posedge clk) disable iff (reset)
    ctrl_q == 8'h00 |=> state_q == ST_OFF && !conv_start)
    else $error("sequencing while powered down");

  c_full_point: cover property (@(posedge clk) disable iff (reset) ev_done);
  c_lift: cover property (@(posedge clk) disable iff (reset)
    state_q == ST_DETECT ##1 state_q == ST_IDLE);
  c_collide: cover property (@(posedge clk) disable iff (reset) irq_event && reg_read);
endmodule

// >>> tb/screen_model.sv
// Behavioural four-wire resistive screen with its comparator
module screen_model
  import touch_seq_pkg::*;
(
  input  wire logic                touched,
  input  wire logic [11:0]         x_pos,
  input  wire logic [11:0]         y_pos,
  input  wire logic [3:0]          plate_out,
  input  wire logic [3:0]          plate_oe_n,
  input  wire logic [11:0]         dac_code,
  output logic [3:0]               plate_in,
  output logic                     comp_above
);
  timeunit 1ns;
  timeprecision 100ps;
  logic                            x_driven;
  logic [11:0]                     level;

  // touch pulls the undriven plate high
  always_comb begin
    x_driven = !plate_oe_n[PIN_X_HIGH] && !plate_oe_n[PIN_X_LOW];
    level = x_driven ? x_pos : y_pos;
    for (int i = 0; i < 4; i++) begin
      // Released pins sink through the decoupling caps unless the plates touch
      plate_in[i] = !plate_oe_n[i] ? plate_out[i] : touched;
    end
  end

  // sensed share of plate voltage against trial code
  assign comp_above = touched && (level >= dac_code);
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the touch conversion sequencer
module testbench
  import touch_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SETTLE_W = 20;
  localparam int P_BASE   = 30;
  localparam int P_STEP   = 2;
  localparam int TIMEOUT  = 20000;
  logic        clk, reset, cfg_write, cfg_sel_rate, reg_read, touched, comp_above, touch_n, irq;
  logic [7:0]  cfg_data;
  logic [3:0]  plate_in, plate_out, plate_oe_n;
  logic [11:0] x_pos, y_pos, dac_code, x_result, y_result;
  int          miscompares, checks_done, cycles, n;

  touch_conversion_sequencer #(.SETTLE_WAIT(SETTLE_W), .PACE_BASE(P_BASE), .PACE_STEP(P_STEP))
  DUT (.clk(clk), .reset(reset), .cfg_write(cfg_write), .cfg_sel_rate(cfg_sel_rate),
       .cfg_data(cfg_data), .reg_read(reg_read), .plate_in(plate_in), .comp_above(comp_above),
       .plate_out(plate_out), .plate_oe_n(plate_oe_n), .dac_code(dac_code),
       .x_result(x_result), .y_result(y_result), .touch_n(touch_n), .irq(irq));

  screen_model screen (.touched(touched), .x_pos(x_pos), .y_pos(y_pos), .plate_out(plate_out),
                       .plate_oe_n(plate_oe_n), .dac_code(dac_code), .plate_in(plate_in),
                       .comp_above(comp_above));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic write_cfg(input logic sel, input logic [7:0] data);
    cfg_sel_rate = sel;
    cfg_data = data;
    cfg_write = 1'b1;
    step(1);
    cfg_write = 1'b0;
  endtask

  task automatic host_read();
    reg_read = 1'b1;
    step(1);
    reg_read = 1'b0;
  endtask

  task automatic wait_irq(input string what);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    check(what, 16'(n < 3000), 16'h1);
  endtask

  task automatic wait_x_drive();
    n = 0;
    while (!(plate_oe_n[PIN_X_HIGH] === 1'b0 && plate_out[PIN_X_HIGH] === 1'b1) && n < 3000) begin
      step(1);
      n++;
    end
  endtask

  task automatic test_reset();
    check("oe after reset", 16'(plate_oe_n), 16'h000f);
    check("results after reset", {x_result, 4'h0} | 16'(y_result), 16'h0);
    check("irq after reset", 16'(irq), 16'h0);
    touched = 1'b1;
    step(3);
    check("touch in power down", 16'(touch_n), 16'h0);
    step(60);
    check("no conversion in power down", 16'(x_result), 16'h0);
    touched = 1'b0;
    step(3);
    check("touch released", 16'(touch_n), 16'h1);
  endtask

  task automatic test_idle_drive();
    // conversions and both interrupt kinds enabled
    write_cfg(1'b0, 8'h07);
    step(2);
    check("idle y high drive", {plate_oe_n[PIN_Y_HIGH], plate_out[PIN_Y_HIGH]}, 16'h1);
    check("idle x low drive", {plate_oe_n[PIN_X_LOW], plate_out[PIN_X_LOW]}, 16'h0);
  endtask

  task automatic test_point(input logic [11:0] x, input logic [11:0] y);
    x_pos = x;
    y_pos = y;
    touched = 1'b1;
    wait_irq("touch interrupt");
    // host traffic placed inside the settle window
    host_read();
    check("irq cleared by read", 16'(irq), 16'h0);
    wait_x_drive();
    check("settle before drive", 16'(n + 1 >= SETTLE_W && n <= SETTLE_W + 2), 16'h1);
    wait_irq("done interrupt");
    check("x result", 16'(x_result), 16'(x));
    check("y result", 16'(y_result), 16'(y));
    check("dac at final code", 16'(dac_code), 16'(y));
    check("touch kept over point", 16'(touch_n), 16'h0);
    host_read();
    step(20);
    check("x held", 16'(x_result), 16'(x));
    check("y held", 16'(y_result), 16'(y));
    touched = 1'b0;
    wait_irq("lift interrupt");
    check("touch after lift", 16'(touch_n), 16'h1);
    host_read();
  endtask

  task automatic test_rate_clamp();
    write_cfg(1'b1, 8'h03);
    x_pos = 12'h5a5;
    y_pos = 12'ha5a;
    touched = 1'b1;
    wait_irq("touch interrupt");
    host_read();
    wait_irq("done interrupt");
    host_read();
    wait_x_drive();
    // Clamped rate of 9 sets pace, then the detect window
    check("clamped pace", 16'(n >= P_BASE + P_STEP * 9 + 16 - 2), 16'h1);
    check("pace bound", 16'(n <= P_BASE + P_STEP * 9 + 16 + 3), 16'h1);
    wait_irq("second done");
    check("repeat x", 16'(x_result), 16'h05a5);
    touched = 1'b0;
    host_read();
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    {cfg_write, cfg_sel_rate, reg_read, touched} = 4'h0;
    cfg_data = 8'h00;
    x_pos = 12'h000;
    y_pos = 12'h000;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    reset = 1'b0;
    step(1);
    test_reset();
    test_idle_drive();
    test_point(12'h9a5, 12'h3c1);
    test_point(12'hfff, 12'h000);
    test_point(12'h000, 12'hfff);
    test_point(12'h800, 12'h7ff);
    test_rate_clamp();
    print_verdict();
  end
endmodule
